//--- sm_params.svh
// Constants of the safe motion request and status block.
// Assumes inclusion by bare name from the package and the design file.
// What this block does
// - A high negative-direction request keeps direction monitoring off.
// - A low request starts negative-only direction monitoring after delay.
// - With the request marked unused, direction monitoring stays off.
// - One position tolerance serves standstill and direction monitoring.
// - A configurable start delay in microseconds precedes monitoring.
// - Acknowledge acts only on a rising edge of the acknowledge input.
// - An option selects automatic acknowledge at startup.
// - Without it the block stays in init until an acknowledge edge.
// - With enable high, ready is high and, in operation, status shows each function.
// - With enable low, ready, the safe status outputs and fail are low.
// - Stop, brake and torque status is high only when active and safe.
// - Those are low when unrequested, in error or disabled.
// - Stop and limit status waits until the safe state is reached.
// - Each speed-limit status depends only on its own function.
// - Increment-limit status is high only when active and safe.
// - A block error is left only on an acknowledge rising edge.
`ifndef SM_PARAMS_SVH
`define SM_PARAMS_SVH
`define CLK_MHZ       25
`define CYCLE_US      1
`define TICK_CNT_W    5
`define TICK_CLKS     (`CLK_MHZ * `CYCLE_US)
`define NUM_FUNC      11
`define NUM_STAT      12
`define ST_OP_STOP    3
`define ST_LIMIT_ONE  6
`define ST_INC_LIMIT  10
`define ST_NEG_DIR    11
`define REG_CTRL      8'h00
`define REG_DELAY     8'h04
`define REG_TOL       8'h08
`define REG_STATE     8'h0c
`define REG_IRQ_STAT  8'h10
`define REG_IRQ_MASK  8'h14
`define DELAY_W       16
`define TOL_W         16
`define IRQ_W         3
`define IRQ_FAIL      0
`define IRQ_DIR_VIOL  1
`define IRQ_OPER      2
`define CTRL_RST      2'h0
`define DELAY_RST     16'h0000
`define TOL_RST       16'h0000
`endif

//--- sm_pkg.sv
// Types shared by the safe motion request and status block.
// Assumes sm_params.svh is on the include path.
`include "sm_params.svh"
package sm_pkg;
    typedef enum logic [1:0] {
        st_init,
        st_oper,
        st_fail
    } mode_e;
    typedef struct packed {
        logic neg_used;
        logic auto_ack;
    } ctrl_s;
endpackage : sm_pkg

//--- safe_motion_request_status.sv
// Safe motion request and status block for one axis, Wishbone slave.
// Assumes all inputs are synchronous to clk_i; monitors outside supply
// per-function request, safe-state and error flags.
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sm_params.svh"
module safe_motion_request_status
    import sm_pkg::*;
#(
    parameter int DELAY_W = `DELAY_W,
    parameter int TOL_W   = `TOL_W
)(
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output var  logic [31:0]              wb_dat_o,
    output var  logic                     wb_ack_o,
    input  wire logic                     enable_i,
    input  wire logic                     neg_direction_request_n_i,
    input  wire logic                     ack_i,
    input  wire logic [`NUM_FUNC-1:0]     func_req_i,
    input  wire logic [`NUM_FUNC-1:0]     func_safe_i,
    input  wire logic [`NUM_FUNC-1:0]     func_err_i,
    input  wire logic                     module_err_i,
    input  wire logic signed [31:0]       position_i,
    output var  logic                     ready_o,
    output var  logic [`NUM_STAT-1:0]     safe_status_o,
    output var  logic                     fail_o,
    output var  logic                     irq_o
);

    // ************************************************************
    // Controller cycle divider
    // ************************************************************
    logic [`TICK_CNT_W-1:0] div_r, div_nxt;
    logic                   tick;

    always_comb begin
        tick    = (div_r == `TICK_CNT_W'(`TICK_CLKS - 1));
        div_nxt = tick ? '0 : div_r + 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // ************************************************************
    // Wishbone register file
    // ************************************************************
    ctrl_s              ctrl_r, ctrl_nxt;
    logic [DELAY_W-1:0] dly_r, dly_nxt;
    logic [TOL_W-1:0]   tol_r, tol_nxt;
    logic [`IRQ_W-1:0]  mask_r, mask_nxt;
    logic [`IRQ_W-1:0]  stat_r, stat_nxt;
    logic [`IRQ_W-1:0]  rd_clr_r, rd_clr_nxt;
    logic [`IRQ_W-1:0]  events;
    logic               ack_nxt, irq_nxt, wr;
    logic [31:0]        rdat_nxt, wmask, wval;
    mode_e              mode_r;
    logic               dir_act_r;

    always_comb begin
        ack_nxt    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        wr         = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
        wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        rdat_nxt   = '0;
        rd_clr_nxt = '0;
        ctrl_nxt   = ctrl_r;
        dly_nxt    = dly_r;
        tol_nxt    = tol_r;
        mask_nxt   = mask_r;
        wval       = '0;
        case (wb_adr_i)
            `REG_CTRL: begin
                rdat_nxt = 32'(ctrl_r);
                wval     = (32'(ctrl_r) & ~wmask) | (wb_dat_i & wmask);
                if (wr) begin
                    ctrl_nxt = ctrl_s'(wval[1:0]);
                end
            end
            `REG_DELAY: begin
                rdat_nxt = 32'(dly_r);
                wval     = (32'(dly_r) & ~wmask) | (wb_dat_i & wmask);
                if (wr) begin
                    dly_nxt = wval[DELAY_W-1:0];
                end
            end
            `REG_TOL: begin
                rdat_nxt = 32'(tol_r);
                wval     = (32'(tol_r) & ~wmask) | (wb_dat_i & wmask);
                if (wr) begin
                    tol_nxt = wval[TOL_W-1:0];
                end
            end
            `REG_STATE: begin
                rdat_nxt = {29'h0, dir_act_r, 2'(mode_r)};
            end
            `REG_IRQ_STAT: begin
                rdat_nxt = 32'(stat_r);
                if (ack_nxt && !wb_we_i) begin
                    rd_clr_nxt = stat_r;
                end
            end
            `REG_IRQ_MASK: begin
                rdat_nxt = 32'(mask_r);
                wval     = (32'(mask_r) & ~wmask) | (wb_dat_i & wmask);
                if (wr) begin
                    mask_nxt = wval[`IRQ_W-1:0];
                end
            end
            default: begin
                rdat_nxt = '0;
            end
        endcase
        // Only bits shown by the read are cleared, so a new event wins.
        stat_nxt = (stat_r & ~rd_clr_r) | events;
        irq_nxt  = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            ctrl_r   <= `CTRL_RST;
            dly_r    <= `DELAY_RST;
            tol_r    <= `TOL_RST;
            mask_r   <= '0;
            stat_r   <= '0;
            rd_clr_r <= '0;
            irq_o    <= 1'b0;
        end else begin
            wb_ack_o <= ack_nxt;
            wb_dat_o <= rdat_nxt;
            ctrl_r   <= ctrl_nxt;
            dly_r    <= dly_nxt;
            tol_r    <= tol_nxt;
            mask_r   <= mask_nxt;
            stat_r   <= stat_nxt;
            rd_clr_r <= rd_clr_nxt;
            irq_o    <= irq_nxt;
        end
    end

    // ************************************************************
    // Acknowledge edge and operating mode
    // ************************************************************
    logic  ack_prev_r, ack_prev_nxt, ack_edge;
    logic  dir_viol;
    mode_e mode_nxt;

    always_comb begin
        // Reset value high: an input held high at power-up is no edge.
        ack_edge     = tick & ack_i & ~ack_prev_r;
        ack_prev_nxt = tick ? ack_i : ack_prev_r;
        mode_nxt     = mode_r;
        events       = '0;
        if (tick) begin
            unique case (mode_r)
                st_init: begin
                    if (ctrl_r.auto_ack || ack_edge) begin
                        mode_nxt = st_oper;
                    end
                end
                st_oper: begin
                    if (module_err_i || dir_viol) begin
                        mode_nxt = st_fail;
                    end
                end
                st_fail: begin
                    if (ack_edge && !module_err_i) begin
                        mode_nxt = st_oper;
                    end
                end
            endcase
        end
        events[`IRQ_FAIL]     = (mode_nxt == st_fail) & (mode_r != st_fail);
        events[`IRQ_OPER]     = (mode_nxt == st_oper) & (mode_r != st_oper);
        events[`IRQ_DIR_VIOL] = tick & dir_viol;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r     <= st_init;
            ack_prev_r <= 1'b1;
        end else begin
            mode_r     <= mode_nxt;
            ack_prev_r <= ack_prev_nxt;
        end
    end

    // ************************************************************
    // Direction and standstill monitoring
    // ************************************************************
    logic [DELAY_W-1:0]   dcnt_r, dcnt_nxt;
    logic                 dir_act_nxt, neg_sel, stand_ok;
    logic signed [31:0]   dref_r, dref_nxt, sref_r, sref_nxt;
    logic signed [33:0]   ddiff, sdiff, tol_s;

    always_comb begin
        neg_sel     = ctrl_r.neg_used & ~neg_direction_request_n_i
                      & (mode_r == st_oper);
        tol_s       = 34'(tol_r);
        ddiff       = 34'(position_i) - 34'(dref_r);
        sdiff       = 34'(position_i) - 34'(sref_r);
        dir_viol    = dir_act_r & (ddiff > tol_s);
        stand_ok    = (sdiff <= tol_s) & (sdiff >= -tol_s);
        dcnt_nxt    = dcnt_r;
        dir_act_nxt = dir_act_r & ctrl_nxt.neg_used;
        dref_nxt    = dref_r;
        sref_nxt    = func_req_i[`ST_OP_STOP] ? sref_r : position_i;
        if (tick) begin
            if (!neg_sel || !ctrl_nxt.neg_used) begin
                dcnt_nxt    = dly_r;
                dir_act_nxt = 1'b0;
            end else if (!dir_act_r) begin
                if (dcnt_r == '0) begin
                    dir_act_nxt = 1'b1;
                    dref_nxt    = position_i;
                end else begin
                    dcnt_nxt = dcnt_r - 1'b1;
                end
            end else if (position_i < dref_r) begin
                // Follow the axis the allowed way; back-off is limited.
                dref_nxt = position_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcnt_r    <= '0;
            dir_act_r <= 1'b0;
            dref_r    <= '0;
            sref_r    <= '0;
        end else begin
            dcnt_r    <= dcnt_nxt;
            dir_act_r <= dir_act_nxt;
            dref_r    <= dref_nxt;
            sref_r    <= sref_nxt;
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    logic [`NUM_STAT-1:0] act, safe, st_nxt;
    logic                 ready_nxt, fail_nxt;

    always_comb begin
        act  = {neg_sel, func_req_i & ~func_err_i};
        safe = {dir_act_r & ~dir_viol, func_safe_i};
        safe[`ST_OP_STOP] = func_safe_i[`ST_OP_STOP] & stand_ok;
        // Each bit stands alone, so one limit never lifts another.
        st_nxt    = (enable_i && mode_r == st_oper) ? (act & safe) : '0;
        ready_nxt = enable_i;
        fail_nxt  = enable_i & (mode_r == st_fail);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_o       <= 1'b0;
            safe_status_o <= '0;
            fail_o        <= 1'b0;
        end else if (tick) begin
            ready_o       <= ready_nxt;
            safe_status_o <= st_nxt;
            fail_o        <= fail_nxt;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ready_follows_en: assert property (
        tick |=> ready_o == $past(enable_i))
        else $error("ready does not follow enable");

    a_disabled_all_low: assert property (
        !ready_o |-> (safe_status_o == '0) && !fail_o)
        else $error("outputs high while disabled");

    a_neg_deselect: assert property (
        tick && neg_direction_request_n_i |=> !safe_status_o[`ST_NEG_DIR])
        else $error("direction status high while deselected");

    a_unused_off: assert property (
        !ctrl_r.neg_used |-> !dir_act_r ##1 !dir_act_r)
        else $error("unused direction monitor became active");

    a_delay_before: assert property (
        $rose(dir_act_r) |-> $past(dcnt_r) == '0 && $past(tick))
        else $error("direction monitor started before its delay");

    a_error_clears: assert property (
        tick && mode_r != st_oper |=> safe_status_o == '0)
        else $error("status high outside operation");

    a_fail_needs_ack: assert property (
        mode_r == st_fail && !ack_edge |=> mode_r == st_fail)
        else $error("error left without acknowledge edge");

    a_init_holds: assert property (
        mode_r == st_init && !ctrl_r.auto_ack && !ack_edge
        |=> mode_r == st_init)
        else $error("init left without acknowledge edge");

    a_auto_start: assert property (
        tick && mode_r == st_init && ctrl_r.auto_ack |=> mode_r == st_oper)
        else $error("automatic startup acknowledge missed");

    a_limit_needs_safe: assert property (
        tick && !func_safe_i[`ST_LIMIT_ONE]
        |=> !safe_status_o[`ST_LIMIT_ONE])
        else $error("limit status high before safe state");

    a_inc_limit_err: assert property (
        tick && func_err_i[`ST_INC_LIMIT] |=> !safe_status_o[`ST_INC_LIMIT])
        else $error("increment status high in error");

    a_status_per_tick: assert property (
        !tick |=> $stable(safe_status_o) && $stable(ready_o))
        else $error("status changed between controller cycles");

endmodule : safe_motion_request_status
`default_nettype wire

//--- ack_source.sv
// Model of the safety program's acknowledge output.
// Assumes one clock shared with the block and a 25-clock controller tick.
`timescale 1ns/1ps
`default_nettype none
module ack_source (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pulse_i,
    output var  logic ack_o,
    output var  logic busy_o
);
    logic [6:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i)
            cnt_r <= 7'h00;
        else if (pulse_i && cnt_r == 7'h00)
            cnt_r <= 7'h64;
        else if (cnt_r != 7'h00)
            cnt_r <= cnt_r - 7'h01;
    end

    // Two ticks high then two low, so each request is one clean edge.
    assign ack_o  = (cnt_r > 7'h32);
    assign busy_o = (cnt_r != 7'h00);
endmodule : ack_source
`default_nettype wire

//--- safe_motion_request_status_bench.sv
// Self-checking bench for the safe motion request and status block.
// Assumes sm_params.svh on the include path and ack_source compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sm_params.svh"
module safe_motion_request_status_bench import sm_pkg::*; ;
    logic                     clk_i = 1'b0;
    logic                     rst_i = 1'b1;
    logic                     cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]               adr = 8'h00;
    logic [31:0]              wdat = 32'h0, rdat, q;
    logic                     wb_ack_o, ready, fail, irq, ack_line, busy;
    logic                     en = 1'b0, req_n = 1'b1, pulse = 1'b0;
    logic                     merr = 1'b0;
    logic [`NUM_FUNC-1:0]     req = '0, safe = '0, err = '0;
    logic [`NUM_STAT-1:0]     stat;
    logic signed [31:0]       pos = 32'sh0;
    int                       failures = 0, samples_checked = 0;

    always #20 clk_i = ~clk_i;

    safe_motion_request_status dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(wb_ack_o), .enable_i(en),
        .neg_direction_request_n_i(req_n), .ack_i(ack_line),
        .func_req_i(req), .func_safe_i(safe), .func_err_i(err),
        .module_err_i(merr), .position_i(pos), .ready_o(ready),
        .safe_status_o(stat), .fail_o(fail), .irq_o(irq));

    ack_source app (.clk_i(clk_i), .rst_i(rst_i), .pulse_i(pulse),
        .ack_o(ack_line), .busy_o(busy));

    // ****************************************
    // Helpers
    // ****************************************
    task wrap_up;
        $display("failures=%0d samples_checked=%0d", failures,
                 samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task ticks(input int n);
        repeat (n) @(posedge clk_i);
    endtask : ticks

    // Status moves only on controller ticks, so allow two whole ticks.
    task settle;
        ticks(52);
    endtask : settle

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1)
                break;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (i == 20) begin
            failures++;
            $display("ERROR bus_ack expected 1 seen %b", wb_ack_o);
            wrap_up();
        end
    endtask : bus

    task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask : rd_chk

    task ack_edge;
        int i;
        pulse <= 1'b1;
        @(posedge clk_i);
        pulse <= 1'b0;
        // The model loads its counter on this edge; busy shows a cycle on.
        @(posedge clk_i);
        for (i = 0; i < 300 && busy !== 1'b0; i++)
            @(posedge clk_i);
        if (i == 300) begin
            failures++;
            $display("ERROR ack_busy expected 0 seen %b", busy);
            wrap_up();
        end
    endtask : ack_edge

    // ****************************************
    // Scenarios
    // ****************************************
    task t_startup;
        en <= 1'b1;
        req <= '1;
        safe <= '1;
        settle();
        chk("status_init", 32'h0, 32'(stat));
        chk("ready_on", 32'h1, 32'(ready));
        rd_chk("ctrl_reset", `REG_CTRL, 32'h0);
        rd_chk("mode_init", `REG_STATE, 32'(st_init));
        bus(1'b1, `REG_IRQ_MASK, 32'h7);
        ack_edge();
        settle();
        rd_chk("mode_oper", `REG_STATE, 32'(st_oper));
        chk("irq_set", 32'h1, 32'(irq));
        rd_chk("irq_stat", `REG_IRQ_STAT, 32'h4);
        ticks(3);
        chk("irq_clear", 32'h0, 32'(irq));
        rd_chk("unmapped", 8'h20, 32'h0);
    endtask : t_startup

    task t_status;
        for (int i = 0; i < `NUM_FUNC; i++) begin
            req <= 11'(1 << i);
            safe <= 11'(1 << i);
            err <= '0;
            settle();
            chk("status_one", 32'(1 << i), 32'(stat));
            safe <= '0;
            settle();
            chk("status_unsafe", 32'h0, 32'(stat));
            safe <= 11'(1 << i);
            err <= 11'(1 << i);
            settle();
            chk("status_err", 32'h0, 32'(stat));
        end
        err <= '0;
        req <= '1;
        safe <= '1;
        en <= 1'b0;
        settle();
        chk("ready_off", 32'h0, 32'(ready));
        chk("status_off", 32'h0, 32'(stat));
        en <= 1'b1;
        settle();
        chk("status_all", 32'h7ff, 32'(stat));
    endtask : t_status

    task t_direction;
        req <= '0;
        safe <= '0;
        req_n <= 1'b0;
        settle();
        chk("dir_unused", 32'h0, 32'(stat[11]));
        req_n <= 1'b1;
        bus(1'b1, `REG_CTRL, 32'h2);
        bus(1'b1, `REG_DELAY, 32'h3);
        bus(1'b1, `REG_TOL, 32'ha);
        rd_chk("tol_back", `REG_TOL, 32'ha);
        settle();
        req_n <= 1'b0;
        ticks(26);
        chk("dir_delay", 32'h0, 32'(stat[11]));
        ticks(150);
        chk("dir_active", 32'h1, 32'(stat[11]));
        rd_chk("state_dir", `REG_STATE, 32'h5);
        pos <= -32'sd5;
        settle();
        chk("neg_move_ok", 32'h0, 32'(fail));
        req_n <= 1'b1;
        settle();
        chk("dir_off", 32'h0, 32'(stat[11]));
        req_n <= 1'b0;
        ticks(150);
        pos <= 32'sd6;
        settle();
        chk("viol_fail", 32'h1, 32'(fail));
        rd_chk("irq_viol", `REG_IRQ_STAT, 32'h3);
        req_n <= 1'b1;
        pos <= 32'sh0;
        settle();
        chk("fail_holds", 32'h1, 32'(fail));
        ack_edge();
        settle();
        rd_chk("fail_left", `REG_STATE, 32'(st_oper));
    endtask : t_direction

    task t_module_err;
        bus(1'b1, `REG_IRQ_MASK, 32'h0);
        req <= '1;
        safe <= '1;
        merr <= 1'b1;
        settle();
        chk("merr_fail", 32'h1, 32'(fail));
        chk("merr_status", 32'h0, 32'(stat));
        chk("irq_masked", 32'h0, 32'(irq));
        merr <= 1'b0;
        settle();
        chk("merr_holds", 32'h1, 32'(fail));
        ack_edge();
        settle();
        chk("merr_left", 32'h0, 32'(fail));
    endtask : t_module_err

    task t_auto_ack;
        rst_i <= 1'b1;
        ticks(2);
        rst_i <= 1'b0;
        ticks(1);
        bus(1'b1, `REG_CTRL, 32'h1);
        settle();
        rd_chk("auto_oper", `REG_STATE, 32'(st_oper));
    endtask : t_auto_ack

    initial begin
        ticks(20);
        rst_i <= 1'b0;
        ticks(1);
        t_startup();
        t_status();
        t_direction();
        t_module_err();
        t_auto_ack();
        wrap_up();
    end
endmodule : safe_motion_request_status_bench
`default_nettype wire
